// ===== verilog/spcfg_map.svh
// Register map, field positions, reset values and widths of the clock and frame generator
`ifndef SPCFG_MAP_SVH
`define SPCFG_MAP_SVH
// ----------------------------------------
// Widths
// ----------------------------------------
`define SPCFG_DIV_W      8
`define SPCFG_PER_W      12
`define SPCFG_WID_W      8
`define SPCFG_ADDR_W     8
// ----------------------------------------
// Byte offsets
// ----------------------------------------
`define SPCFG_OFS_CFG1   8'h00
`define SPCFG_OFS_CFG2   8'h04
`define SPCFG_OFS_PIN    8'h08
`define SPCFG_OFS_CTRL   8'h0c
`define SPCFG_OFS_STAT   8'h10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPCFG_DIV_LSB    0
`define SPCFG_WID_LSB    8
`define SPCFG_PER_LSB    0
`define SPCFG_FSSEL_BIT  12
`define SPCFG_SYNC_BIT   15
`define SPCFG_RXCP_BIT   0
`define SPCFG_TXCP_BIT   1
`define SPCFG_RXFP_BIT   2
`define SPCFG_TXFP_BIT   3
`define SPCFG_RXCM_BIT   8
`define SPCFG_TXCM_BIT   9
`define SPCFG_RXFM_BIT   10
`define SPCFG_TXFM_BIT   11
`define SPCFG_FGEN_BIT   0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPCFG_DIV_RST    8'h01
`endif

// ===== verilog/spcfg_pkg.sv
// Types shared by the clock and frame generator modules
package spcfg_pkg;
  `include "spcfg_map.svh"

  typedef struct packed {
    logic [`SPCFG_DIV_W-1:0] cnt;
    logic                    clk;
  } spcfg_div_st_t;

  typedef struct packed {
    logic [`SPCFG_PER_W-1:0] per_cnt;
    logic [`SPCFG_WID_W-1:0] wid_cnt;
    logic                    fs;
    logic                    run;
    logic                    sync_pend;
  } spcfg_frm_st_t;

  typedef struct packed {
    logic [`SPCFG_DIV_W-1:0] div;
    logic [`SPCFG_WID_W-1:0] wid;
    logic [`SPCFG_PER_W-1:0] per;
    logic                    fs_sel;
    logic                    gen_sync;
    logic                    fgen_rst_n;
    logic                    rxcp;
    logic                    txcp;
    logic                    rxfp;
    logic                    txfp;
    logic                    rxcm;
    logic                    txcm;
    logic                    rxfm;
    logic                    txfm;
    logic                    rxc_p;
    logic                    txc_p;
    logic                    rxf_p;
    logic                    copy_pend;
    logic                    copy_fs;
    logic                    rx_smp;
    logic                    tx_lau;
    logic                    rx_frm;
    logic                    tx_frm;
    logic [31:0]             rdata;
  } spcfg_top_st_t;
endpackage : spcfg_pkg

// ===== verilog/spcfg_gen_if.sv
// Bit clock and sync event carrier between divider, frame counters and top
`timescale 1ns/1ps
interface spcfg_gen_if;
  logic gen_bit_clock;
  logic rise;
  logic fall;
  logic sync_evt;
  modport div (output gen_bit_clock, output rise, output fall, input sync_evt);
  modport frm (input rise, input sync_evt);
  modport top (input gen_bit_clock, input rise, input fall, output sync_evt);
endinterface : spcfg_gen_if

// ===== verilog/spcfg_div.sv
// Bit clock divider with optional restart on a sync event
`timescale 1ns/1ps
module spcfg_div
  import spcfg_pkg::*;
#(
  parameter int DIV_W = `SPCFG_DIV_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Configuration
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             gen_sync_i,
  // Generator side
  spcfg_gen_if.div              gen
);
  if (DIV_W != `SPCFG_DIV_W) begin : g_chk
    $error("spcfg_div: DIV_W must match the divider field width");
  end

  spcfg_div_st_t st_q;
  spcfg_div_st_t st_d;
  logic [DIV_W:0] high_len;

  // Odd divide: the high phase is the longer one
  always_comb begin
    high_len = ({1'b0, div_i} + (DIV_W+1)'(2)) >> 1;
    st_d = st_q;
    if (gen_sync_i && gen.sync_evt) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= div_i) begin
      st_d.cnt = '0;
    end else begin
      st_d.cnt = st_q.cnt + DIV_W'(1);
    end
    st_d.clk = ({1'b0, st_d.cnt} < high_len);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign gen.gen_bit_clock = st_q.clk;
  // Tick in the last count, so frame logic switches as the bit clock rises
  assign gen.rise          = (st_q.cnt >= div_i);
  assign gen.fall          = (div_i != '0) && ({1'b0, st_q.cnt} == high_len);
endmodule : spcfg_div

// ===== verilog/spcfg_frame.sv
// Frame period and pulse width down-counters
`timescale 1ns/1ps
module spcfg_frame
  import spcfg_pkg::*;
#(
  parameter int PER_W = `SPCFG_PER_W,
  parameter int WID_W = `SPCFG_WID_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Configuration
  input  wire logic [PER_W-1:0] per_i,
  input  wire logic [WID_W-1:0] wid_i,
  input  wire logic             gen_sync_i,
  input  wire logic             enable_i,
  // Generator side
  spcfg_gen_if.frm              gen,
  // Frame pulse
  output logic                  fs_o
);
  if (PER_W != `SPCFG_PER_W || WID_W != `SPCFG_WID_W) begin : g_chk
    $error("spcfg_frame: counter widths must match the field widths");
  end

  spcfg_frm_st_t st_q;
  spcfg_frm_st_t st_d;
  logic          start;

  always_comb begin
    st_d = st_q;
    // A sync pulse arriving on the consuming tick is kept
    st_d.sync_pend = st_q.sync_pend && !gen.rise;
    if (gen_sync_i && gen.sync_evt) begin
      st_d.sync_pend = 1'b1;
    end
    if (gen_sync_i) begin
      start = st_q.sync_pend;
    end else begin
      start = !st_q.run || (st_q.per_cnt == '0);
    end
    if (!enable_i) begin
      st_d.fs      = 1'b0;
      st_d.run     = 1'b0;
      // A sync seen while disabled must not start a stale frame later
      st_d.sync_pend = 1'b0;
      st_d.per_cnt = '0;
      st_d.wid_cnt = '0;
    end else if (gen.rise) begin
      if (start) begin
        st_d.fs      = 1'b1;
        st_d.run     = 1'b1;
        st_d.per_cnt = per_i;
        st_d.wid_cnt = wid_i;
      end else begin
        st_d.per_cnt = st_q.per_cnt - PER_W'(1);
        if (st_q.wid_cnt == '0) begin
          st_d.fs = 1'b0;
        end else begin
          st_d.wid_cnt = st_q.wid_cnt - WID_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fs_o = st_q.fs;
endmodule : spcfg_frame

// ===== verilog/spcfg_top.sv
// Clock and frame-sync generation, pin polarity and edge selection, APB registers
`timescale 1ns/1ps
module spcfg_top
  import spcfg_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Transmit clock pin
  input  wire logic        TX_CLOCK_PIN_I,
  output logic             TX_CLOCK_PIN_O,
  output logic             TX_CLOCK_PIN_OE_O,
  // Receive clock pin
  input  wire logic        RX_CLOCK_PIN_I,
  output logic             RX_CLOCK_PIN_O,
  output logic             RX_CLOCK_PIN_OE_O,
  // Frame-sync pins
  input  wire logic        TX_FS_PIN_I,
  output logic             TX_FS_PIN_O,
  output logic             TX_FS_PIN_OE_O,
  input  wire logic        RX_FS_PIN_I,
  output logic             RX_FS_PIN_O,
  output logic             RX_FS_PIN_OE_O,
  // Data path side
  input  wire logic        TX_COPY_I,
  output logic             RX_SAMPLE_O,
  output logic             TX_LAUNCH_O,
  output logic             INT_RX_FRAME_O,
  output logic             INT_TX_FRAME_O,
  output logic             GEN_BIT_CLOCK_O,
  output logic             GEN_FRAME_PULSE_O
);
  // ----------------------------------------
  // Local signals
  // ----------------------------------------
  spcfg_gen_if   gen_if ();
  spcfg_top_st_t st_q;
  spcfg_top_st_t st_d;
  logic          gen_frame_pulse;
  logic          int_rx_clock;
  logic          int_tx_clock;
  logic          rx_fs_in;
  logic          tx_fs_in;
  logic          rx_fall;
  logic          tx_rise;
  logic          tx_fall;
  logic          setup;
  logic          wr_en;
  logic          known;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `SPCFG_OFS_CFG1) || (a == `SPCFG_OFS_CFG2) ||
                 (a == `SPCFG_OFS_PIN)  || (a == `SPCFG_OFS_CTRL) ||
                 (a == `SPCFG_OFS_STAT);
  endfunction : addr_known

  // ----------------------------------------
  // Generator
  // ----------------------------------------
  spcfg_div #(
    .DIV_W (`SPCFG_DIV_W)
  ) u_div (
    .clk_i   (CLK_I),
    .rst_i   (RESET_I),
    .div_i   (st_q.div),
    .gen_sync_i (st_q.gen_sync),
    .gen     (gen_if.div)
  );

  spcfg_frame #(
    .PER_W (`SPCFG_PER_W),
    .WID_W (`SPCFG_WID_W)
  ) u_frame (
    .clk_i    (CLK_I),
    .rst_i    (RESET_I),
    .per_i    (st_q.per),
    .wid_i    (st_q.wid),
    .gen_sync_i (st_q.gen_sync),
    .enable_i (st_q.fgen_rst_n && st_q.fs_sel),
    .gen      (gen_if.frm),
    .fs_o     (gen_frame_pulse)
  );

  // ----------------------------------------
  // Internal clocks and frames
  // ----------------------------------------
  // Pin inputs are synchronous to CLK_I, so edges are found by a one-cycle compare
  assign int_tx_clock = st_q.txcm ? gen_if.gen_bit_clock
                                  : (TX_CLOCK_PIN_I ^ st_q.txcp);
  assign int_rx_clock = st_q.rxcm ? gen_if.gen_bit_clock
                                  : (RX_CLOCK_PIN_I ^ st_q.rxcp);
  assign rx_fs_in     = RX_FS_PIN_I ^ st_q.rxfp;
  assign tx_fs_in     = TX_FS_PIN_I ^ st_q.txfp;
  assign rx_fall      = st_q.rxc_p && !int_rx_clock;
  assign tx_fall      = st_q.txc_p && !int_tx_clock;
  assign tx_rise      = !st_q.txc_p && int_tx_clock;
  assign gen_if.sync_evt = st_q.gen_sync && rx_fs_in && !st_q.rxf_p;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign setup = PSEL_I && !PENABLE_I;
  assign known = addr_known(PADDR_I);
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && known;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d        = st_q;
    st_d.rxc_p  = int_rx_clock;
    st_d.txc_p  = int_tx_clock;
    st_d.rxf_p  = rx_fs_in;
    st_d.rx_smp = rx_fall;
    st_d.tx_lau = tx_rise;
    // Copy request survives until the next bit clock tick takes it
    st_d.copy_pend = TX_COPY_I || (st_q.copy_pend && !gen_if.rise);
    if (gen_if.rise) begin
      st_d.copy_fs = st_q.copy_pend;
    end
    if (st_q.rxfm) begin
      st_d.rx_frm = gen_frame_pulse;
    end else if (rx_fall) begin
      st_d.rx_frm = rx_fs_in;
    end
    if (st_q.txfm) begin
      st_d.tx_frm = st_q.fs_sel ? gen_frame_pulse : st_q.copy_fs;
    end else if (tx_fall) begin
      st_d.tx_frm = tx_fs_in;
    end
    if (wr_en) begin
      case (PADDR_I)
        `SPCFG_OFS_CFG1: begin
          st_d.div = PWDATA_I[`SPCFG_DIV_LSB +: `SPCFG_DIV_W];
          st_d.wid = PWDATA_I[`SPCFG_WID_LSB +: `SPCFG_WID_W];
        end
        `SPCFG_OFS_CFG2: begin
          st_d.per    = PWDATA_I[`SPCFG_PER_LSB +: `SPCFG_PER_W];
          st_d.fs_sel = PWDATA_I[`SPCFG_FSSEL_BIT];
          st_d.gen_sync = PWDATA_I[`SPCFG_SYNC_BIT];
        end
        `SPCFG_OFS_PIN: begin
          st_d.rxcp = PWDATA_I[`SPCFG_RXCP_BIT];
          st_d.txcp = PWDATA_I[`SPCFG_TXCP_BIT];
          st_d.rxfp = PWDATA_I[`SPCFG_RXFP_BIT];
          st_d.txfp = PWDATA_I[`SPCFG_TXFP_BIT];
          st_d.rxcm = PWDATA_I[`SPCFG_RXCM_BIT];
          st_d.txcm = PWDATA_I[`SPCFG_TXCM_BIT];
          st_d.rxfm = PWDATA_I[`SPCFG_RXFM_BIT];
          st_d.txfm = PWDATA_I[`SPCFG_TXFM_BIT];
        end
        `SPCFG_OFS_CTRL: begin
          st_d.fgen_rst_n = PWDATA_I[`SPCFG_FGEN_BIT];
        end
        default: begin
        end
      endcase
    end
    // Read data is built in the setup cycle so it is a flop in the access cycle
    if (setup) begin
      st_d.rdata = '0;
      case (PADDR_I)
        `SPCFG_OFS_CFG1: begin
          st_d.rdata[`SPCFG_DIV_LSB +: `SPCFG_DIV_W] = st_q.div;
          st_d.rdata[`SPCFG_WID_LSB +: `SPCFG_WID_W] = st_q.wid;
        end
        `SPCFG_OFS_CFG2: begin
          st_d.rdata[`SPCFG_PER_LSB +: `SPCFG_PER_W] = st_q.per;
          st_d.rdata[`SPCFG_FSSEL_BIT] = st_q.fs_sel;
          st_d.rdata[`SPCFG_SYNC_BIT] = st_q.gen_sync;
        end
        `SPCFG_OFS_PIN: begin
          st_d.rdata[`SPCFG_RXCP_BIT] = st_q.rxcp;
          st_d.rdata[`SPCFG_TXCP_BIT] = st_q.txcp;
          st_d.rdata[`SPCFG_RXFP_BIT] = st_q.rxfp;
          st_d.rdata[`SPCFG_TXFP_BIT] = st_q.txfp;
          st_d.rdata[`SPCFG_RXCM_BIT] = st_q.rxcm;
          st_d.rdata[`SPCFG_TXCM_BIT] = st_q.txcm;
          st_d.rdata[`SPCFG_RXFM_BIT] = st_q.rxfm;
          st_d.rdata[`SPCFG_TXFM_BIT] = st_q.txfm;
        end
        `SPCFG_OFS_CTRL: begin
          st_d.rdata[`SPCFG_FGEN_BIT] = st_q.fgen_rst_n;
        end
        `SPCFG_OFS_STAT: begin
          st_d.rdata[5:0] = {st_q.tx_frm, st_q.rx_frm, int_tx_clock,
                             int_rx_clock, gen_frame_pulse, gen_if.gen_bit_clock};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st_q     <= '0;
      st_q.div <= `SPCFG_DIV_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PRDATA_O  = st_q.rdata;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !known;

  assign TX_CLOCK_PIN_O    = gen_if.gen_bit_clock ^ st_q.txcp;
  assign TX_CLOCK_PIN_OE_O = st_q.txcm;
  assign RX_CLOCK_PIN_O    = gen_if.gen_bit_clock ^ st_q.rxcp;
  assign RX_CLOCK_PIN_OE_O = st_q.rxcm;
  assign TX_FS_PIN_O    = st_q.tx_frm ^ (st_q.txfp && !st_q.gen_sync);
  assign TX_FS_PIN_OE_O = st_q.txfm;
  assign RX_FS_PIN_O    = st_q.rx_frm ^ (st_q.rxfp && !st_q.gen_sync);
  assign RX_FS_PIN_OE_O = st_q.rxfm;

  assign RX_SAMPLE_O       = st_q.rx_smp;
  assign TX_LAUNCH_O       = st_q.tx_lau;
  assign INT_RX_FRAME_O    = st_q.rx_frm;
  assign INT_TX_FRAME_O    = st_q.tx_frm;
  assign GEN_BIT_CLOCK_O   = gen_if.gen_bit_clock;
  assign GEN_FRAME_PULSE_O = gen_frame_pulse;
endmodule : spcfg_top

// ===== tb/spcfg_top_assertions.sv
// Port checker for the clock and frame generator, bound to its top module
`timescale 1ns/1ps
`include "spcfg_map.svh"
module spcfg_top_assertions (
  // Clock, reset and bus
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // Pins and internal signals
  input wire logic        TX_CLOCK_PIN_I,
  input wire logic        TX_CLOCK_PIN_O,
  input wire logic        TX_CLOCK_PIN_OE_O,
  input wire logic        RX_CLOCK_PIN_O,
  input wire logic        RX_CLOCK_PIN_OE_O,
  input wire logic        TX_FS_PIN_O,
  input wire logic        TX_FS_PIN_OE_O,
  input wire logic        RX_FS_PIN_O,
  input wire logic        RX_FS_PIN_OE_O,
  input wire logic        RX_SAMPLE_O,
  input wire logic        TX_LAUNCH_O,
  input wire logic        INT_TX_FRAME_O,
  input wire logic        INT_RX_FRAME_O,
  input wire logic        GEN_BIT_CLOCK_O,
  input wire logic        GEN_FRAME_PULSE_O
);
  // Shadow: [11:0] pin control, [12] source select, [13] sync, [14] frame enable
  logic [14:0] cfg_q;
  logic        en;
  assign en = cfg_q[14] & cfg_q[12];
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      cfg_q <= '0;
    end else if (PSEL_I && PENABLE_I && PWRITE_I) begin
      case (PADDR_I)
        `SPCFG_OFS_CFG2: cfg_q[13:12] <= {PWDATA_I[15], PWDATA_I[12]};
        `SPCFG_OFS_PIN:  cfg_q[11:0] <= PWDATA_I[11:0];
        `SPCFG_OFS_CTRL: cfg_q[14] <= PWDATA_I[0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  a_bus_ready: assert property (PREADY_O) else $error("ready low");
  a_unmapped_err: assert property (PSEL_I && PENABLE_I |-> PSLVERR_O == !(PADDR_I inside
    {`SPCFG_OFS_CFG1, `SPCFG_OFS_CFG2, `SPCFG_OFS_PIN, `SPCFG_OFS_CTRL, `SPCFG_OFS_STAT}))
    else $error("bus error flag wrong");
  a_pin_dirs: assert property (TX_CLOCK_PIN_OE_O == cfg_q[9] &&
    RX_CLOCK_PIN_OE_O == cfg_q[8] && TX_FS_PIN_OE_O == cfg_q[11] && RX_FS_PIN_OE_O == cfg_q[10])
    else $error("pin direction wrong");
  a_tx_clk_out: assert property (TX_CLOCK_PIN_OE_O |->
    TX_CLOCK_PIN_O == (GEN_BIT_CLOCK_O ^ cfg_q[1])) else $error("tx clock pin");
  a_rx_clk_out: assert property (RX_CLOCK_PIN_OE_O |->
    RX_CLOCK_PIN_O == (GEN_BIT_CLOCK_O ^ cfg_q[0])) else $error("rx clock pin");
  a_tx_fs_out: assert property (TX_FS_PIN_OE_O |-> TX_FS_PIN_O ==
    (INT_TX_FRAME_O ^ (cfg_q[3] & ~cfg_q[13]))) else $error("tx frame pin");
  a_rx_fs_out: assert property (RX_FS_PIN_O ==
    (INT_RX_FRAME_O ^ (cfg_q[2] & ~cfg_q[13]))) else $error("rx frame pin");
  a_frame_idle: assert property (!en && !$past(en) && !$past(en, 2) |->
    !GEN_FRAME_PULSE_O) else $error("frame while disabled");
  a_frame_on_tick: assert property ($rose(GEN_FRAME_PULSE_O) |-> GEN_BIT_CLOCK_O)
    else $error("frame off tick");
  a_launch_int: assert property (cfg_q[9] && $past(cfg_q[9]) && $rose(GEN_BIT_CLOCK_O)
    |=> TX_LAUNCH_O) else $error("no launch");
  a_sample_int: assert property (cfg_q[8] && $past(cfg_q[8]) && $fell(GEN_BIT_CLOCK_O)
    |=> RX_SAMPLE_O) else $error("no sample");
  a_launch_ext: assert property (!cfg_q[9] && $stable(cfg_q[9:0]) &&
    $rose(TX_CLOCK_PIN_I ^ cfg_q[1]) |=> TX_LAUNCH_O) else $error("no ext launch");
  c_frame: cover property ($rose(GEN_FRAME_PULSE_O));
  c_sync: cover property (cfg_q[13] && $rose(GEN_FRAME_PULSE_O));
  c_ext_launch: cover property (!cfg_q[9] && TX_LAUNCH_O);
  c_bad_addr: cover property (PSLVERR_O);
endmodule : spcfg_top_assertions

bind spcfg_top spcfg_top_assertions u_chk (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .TX_CLOCK_PIN_I(TX_CLOCK_PIN_I), .TX_CLOCK_PIN_O(TX_CLOCK_PIN_O),
  .TX_CLOCK_PIN_OE_O(TX_CLOCK_PIN_OE_O), .RX_CLOCK_PIN_O(RX_CLOCK_PIN_O),
  .RX_CLOCK_PIN_OE_O(RX_CLOCK_PIN_OE_O), .TX_FS_PIN_O(TX_FS_PIN_O),
  .TX_FS_PIN_OE_O(TX_FS_PIN_OE_O), .RX_FS_PIN_OE_O(RX_FS_PIN_OE_O),
  .RX_SAMPLE_O(RX_SAMPLE_O), .TX_LAUNCH_O(TX_LAUNCH_O), .INT_TX_FRAME_O(INT_TX_FRAME_O),
  .RX_FS_PIN_O(RX_FS_PIN_O), .INT_RX_FRAME_O(INT_RX_FRAME_O),
  .GEN_BIT_CLOCK_O(GEN_BIT_CLOCK_O), .GEN_FRAME_PULSE_O(GEN_FRAME_PULSE_O)
);

// ===== tb/spcfg_peer.sv
// Behavioural external serial device: clock and frame pulse source
`timescale 1ns/1ps
module spcfg_peer #(
  parameter int HALF = 3
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control from the bench
  input  wire logic run_i,
  input  wire logic fs_req_i,
  input  wire logic fs_low_i,
  // Pins towards the device
  output logic      clk_o,
  output logic      fs_o
);
  int ph_q;
  int fs_q;
  // Clock stands still at 0 outside bursts, as a slave sees it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_q  <= 0;
      clk_o <= 1'b0;
      fs_q  <= 0;
    end else begin
      if (!run_i) begin
        ph_q  <= 0;
        clk_o <= 1'b0;
      end else if (ph_q == HALF - 1) begin
        ph_q  <= 0;
        clk_o <= ~clk_o;
      end else begin
        ph_q <= ph_q + 1;
      end
      fs_q <= fs_req_i ? 2 * HALF : (fs_q > 0 ? fs_q - 1 : 0);
    end
  end
  // Pulse lasts one peer clock period; active low on request
  assign fs_o = (fs_q > 0) ^ fs_low_i;
endmodule : spcfg_peer

// ===== tb/tb.sv
// Self-checking bench for the clock and frame generator
`timescale 1ns/1ps
`include "spcfg_map.svh"
module tb;
  logic        CLK_I, RESET_I, PSEL_I, PENABLE_I, PWRITE_I, TX_COPY_I;
  logic [7:0]  PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O;
  logic        PREADY_O, PSLVERR_O, RX_SAMPLE_O, TX_LAUNCH_O;
  logic        TX_CLOCK_PIN_O, TX_CLOCK_PIN_OE_O, RX_CLOCK_PIN_O, RX_CLOCK_PIN_OE_O;
  logic        TX_FS_PIN_O, TX_FS_PIN_OE_O, RX_FS_PIN_O, RX_FS_PIN_OE_O;
  logic        INT_RX_FRAME_O, INT_TX_FRAME_O, GEN_BIT_CLOCK_O, GEN_FRAME_PULSE_O;
  logic        tx_clk_w, rx_clk_w, tx_fs_w, rx_fs_w, p_clk, p_fs, p_run, p_req, p_low;
  logic        mon;
  int          errors, n_compared, mon_sel;
  int          tab [3][3] = '{'{1, 1, 3}, '{2, 0, 5}, '{0, 2, 6}};
  // Pins resolve to whichever side drives them
  assign tx_clk_w = TX_CLOCK_PIN_OE_O ? TX_CLOCK_PIN_O : p_clk;
  assign rx_clk_w = RX_CLOCK_PIN_OE_O ? RX_CLOCK_PIN_O : p_clk;
  assign tx_fs_w = TX_FS_PIN_OE_O ? TX_FS_PIN_O : p_fs;
  assign rx_fs_w = RX_FS_PIN_OE_O ? RX_FS_PIN_O : p_fs;
  assign mon = (mon_sel == 0) ? GEN_FRAME_PULSE_O : (mon_sel == 1) ? INT_TX_FRAME_O
             : INT_RX_FRAME_O;
  spcfg_top dut (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TX_CLOCK_PIN_I(tx_clk_w),
    .TX_CLOCK_PIN_O(TX_CLOCK_PIN_O), .TX_CLOCK_PIN_OE_O(TX_CLOCK_PIN_OE_O),
    .RX_CLOCK_PIN_I(rx_clk_w), .RX_CLOCK_PIN_O(RX_CLOCK_PIN_O),
    .RX_CLOCK_PIN_OE_O(RX_CLOCK_PIN_OE_O), .TX_FS_PIN_I(tx_fs_w), .TX_FS_PIN_O(TX_FS_PIN_O),
    .TX_FS_PIN_OE_O(TX_FS_PIN_OE_O), .RX_FS_PIN_I(rx_fs_w), .RX_FS_PIN_O(RX_FS_PIN_O),
    .RX_FS_PIN_OE_O(RX_FS_PIN_OE_O), .TX_COPY_I(TX_COPY_I), .RX_SAMPLE_O(RX_SAMPLE_O),
    .TX_LAUNCH_O(TX_LAUNCH_O), .INT_RX_FRAME_O(INT_RX_FRAME_O),
    .INT_TX_FRAME_O(INT_TX_FRAME_O), .GEN_BIT_CLOCK_O(GEN_BIT_CLOCK_O),
    .GEN_FRAME_PULSE_O(GEN_FRAME_PULSE_O)
  );
  spcfg_peer #(.HALF(3)) u_peer (
    .clk_i(CLK_I), .rst_i(RESET_I), .run_i(p_run), .fs_req_i(p_req), .fs_low_i(p_low),
    .clk_o(p_clk), .fs_o(p_fs)
  );
  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // Request held until the edge that sees ready; released only after it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    PSEL_I    <= 1'b1;
    PENABLE_I <= 1'b0;
    PWRITE_I  <= wr;
    PADDR_I   <= a;
    PWDATA_I  <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 50);
    r = PRDATA_O;
    e = PSLVERR_O;
    PSEL_I    <= 1'b0;
    PENABLE_I <= 1'b0;
    @(posedge CLK_I);
    if (n >= 50) begin
      errors++;
      $display("FAIL bus ready expected 1 seen %b", PREADY_O);
      end_of_test;
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
    chk({nm, "_err"}, {31'h0, xe}, {31'h0, e});
  endtask : rd
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (mon !== v && n < 3000) begin
      @(posedge CLK_I);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      $display("FAIL monitor expected %b seen %b", v, mon);
      end_of_test;
    end
  endtask : wait_lvl
  task automatic count(input int c, output int nr, output int ns, output int nl);
    logic pm;
    nr = 0;
    ns = 0;
    nl = 0;
    pm = mon;
    repeat (c) begin
      @(posedge CLK_I);
      nr += int'(mon === 1'b1 && pm === 1'b0);
      ns += int'(RX_SAMPLE_O === 1'b1);
      nl += int'(TX_LAUNCH_O === 1'b1);
      pm = mon;
    end
  endtask : count
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n, hi, lo, nr, ns, nl;
    {PSEL_I, PENABLE_I, PWRITE_I, TX_COPY_I, p_run, p_req, p_low} = '0;
    PADDR_I = 8'h00;
    PWDATA_I = 32'h0;
    errors = 0;
    n_compared = 0;
    mon_sel = 0;
    RESET_I = 1'b1;
    repeat (3) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    rd("cfg1", `SPCFG_OFS_CFG1, 32'h1, 1'b0);
    rd("cfg2", `SPCFG_OFS_CFG2, 32'h0, 1'b0);
    rd("unmapped", 8'h20, 32'h0, 1'b1);
    wr(8'h14, 32'h0000_ffff);
    wr(`SPCFG_OFS_PIN, 32'h0000_0b0b);
    rd("pin", `SPCFG_OFS_PIN, 32'h0000_0b0b, 1'b0);
    wr(`SPCFG_OFS_CFG1, 32'h0000_0101);
    wr(`SPCFG_OFS_CFG2, 32'h0000_1003);
    count(40, nr, ns, nl);
    chk("frame_held", 0, nr);
    wr(`SPCFG_OFS_CFG2, 32'h0000_0003);
    wr(`SPCFG_OFS_CTRL, 32'h1);
    count(40, nr, ns, nl);
    chk("frame_other_src", 0, nr);
    foreach (tab[i]) begin
      wr(`SPCFG_OFS_CTRL, 32'h0);
      wr(`SPCFG_OFS_CFG1, (tab[i][1] << 8) | tab[i][0]);
      wr(`SPCFG_OFS_CFG2, 32'h1000 | tab[i][2]);
      wr(`SPCFG_OFS_CTRL, 32'h1);
      wait_lvl(1'b1, n);
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, lo);
      chk("frame_width", (tab[i][1] + 1) * (tab[i][0] + 1), hi);
      chk("frame_period", (tab[i][2] + 1) * (tab[i][0] + 1), hi + lo);
    end
    wr(`SPCFG_OFS_CTRL, 32'h0);
    wr(`SPCFG_OFS_CFG1, 32'h0000_0101);
    wr(`SPCFG_OFS_CFG2, 32'h0000_9003);
    wr(`SPCFG_OFS_CTRL, 32'h1);
    count(40, nr, ns, nl);
    chk("sync_idle", 0, nr);
    p_req <= 1'b1;
    @(posedge CLK_I);
    p_req <= 1'b0;
    wait_lvl(1'b1, n);
    chk("sync_start_soon", 1, n <= 8);
    wait_lvl(1'b0, hi);
    chk("sync_width", 4, hi);
    count(40, nr, ns, nl);
    chk("sync_single", 0, nr);
    mon_sel = 1;
    wr(`SPCFG_OFS_CFG2, 32'h0000_0003);
    TX_COPY_I <= 1'b1;
    @(posedge CLK_I);
    TX_COPY_I <= 1'b0;
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, hi);
    chk("copy_width", 2, hi);
    wr(`SPCFG_OFS_PIN, 32'h0000_0007);
    p_low <= 1'b1;
    p_run <= 1'b1;
    count(12, nr, ns, nl);
    count(48, nr, ns, nl);
    chk("rx_samples", 8, ns);
    chk("tx_launches", 8, nl);
    mon_sel = 2;
    p_req <= 1'b1;
    @(posedge CLK_I);
    p_req <= 1'b0;
    wait_lvl(1'b1, n);
    chk("rx_frame_in", 1, n <= 20);
    p_run <= 1'b0;
    end_of_test;
  end
endmodule : tb
